// ==== hdl/iexr_alu.sv ====
// arithmetic and logic unit for the executed instruction subset
`timescale 1ns/10ps
module iexr_alu (
	input wire iexr_pkg::iexr_op_t op, // executed operation
	input wire logic [7:0] acc, // accumulator
	input wire logic [7:0] file_val, // addressed file register
	input wire logic [7:0] lit, // immediate byte
	input wire logic carry_in, // current carry flag
	output iexr_pkg::iexr_alu_t alu // result and flag updates
);
	logic [7:0] minuend;
	logic [8:0] diff;
	logic [4:0] half;

	always_comb begin
		minuend = (op == iexr_pkg::OP_LIT_SUB) ? lit : file_val;
		diff = {1'b0, minuend} - {1'b0, acc};
		half = {1'b0, minuend[3:0]} - {1'b0, acc[3:0]};
		alu = '0;
		unique case (op)
			iexr_pkg::OP_LIT_SUB, iexr_pkg::OP_FILE_SUB: begin
				alu.res = diff[7:0]; // RULE_07
				alu.c = ~diff[8]; // RULE_12
				alu.hb = ~half[4]; // RULE_09
				alu.wr_c = 1'b1;
				alu.wr_hb = 1'b1;
				alu.wr_z = 1'b1;
			end
			iexr_pkg::OP_XOR_LIT: begin
				alu.res = acc ^ lit; // RULE_08
				alu.wr_z = 1'b1;
			end
			iexr_pkg::OP_XOR_FILE: begin
				alu.res = acc ^ file_val; // RULE_10
				alu.wr_z = 1'b1;
			end
			iexr_pkg::OP_ROT_RIGHT: begin
				alu.res = {carry_in, file_val[7:1]}; // RULE_02
				alu.c = file_val[0];
				alu.wr_c = 1'b1;
			end
			iexr_pkg::OP_NIB_SWAP: begin
				alu.res = {file_val[3:0], file_val[7:4]}; // RULE_11
			end
			default: begin
				alu.res = acc;
			end
		endcase
		alu.z = (alu.res == 8'h00); // RULE_12
	end
endmodule : iexr_alu

// ==== hdl/iexr_core.sv ====
// instruction execution core for returns, rotate, subtract, xor, swap and power-down
// Overview of operation
// RULE_01: return_with_literal loads immediate into accumulator, pc from stack_head, two cycles.
// RULE_02: rotate right through carry: old carry enters bit 7, bit 0 to carry.
// RULE_03: destination bit 0 writes accumulator, 1 writes back the file register.
// RULE_04: plain return pops stack into pc, two cycles, no flags touched.
// RULE_05: power-down clears watchdog and prescaler, sets expiry flag, clears powerdown flag.
// RULE_06: after power-down the core sleeps with the main oscillator stopped.
// RULE_07: literal_minus_acc writes immediate minus accumulator, updates carry, half, zero.
// RULE_08: xor_literal writes accumulator xor immediate; only zero flag changes.
// RULE_09: file_minus_acc writes file minus accumulator to destination, updates three flags.
// RULE_10: xor_file writes accumulator xor file to destination; only zero flag changes.
// RULE_11: nibble_exchange swaps file nibbles into destination, no flags touched.
// RULE_12: subtract sets carry when no borrow, zero when result is zero.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "iexr_regs.svh"
module iexr_core #(
	parameter int STACK_DEPTH = 8, // return stack levels
	parameter int FILE_WORDS = 128, // file registers
	parameter int PRESCALE_W = 7 // watchdog prescaler width
) (
	input wire logic SYS_CLK, // 40 MHz clock
	input wire logic RESET_N, // asynchronous reset
	input wire logic INSTR_VALID, // instruction word present
	input wire logic [13:0] INSTR_WORD, // instruction word
	output logic INSTR_READY, // core can take a word this cycle
	output logic [12:0] PC, // program counter
	input wire logic PUSH_REQ, // push a return address
	input wire logic [12:0] PUSH_ADDR, // address to push
	input wire logic WAKE, // wake-up pin
	output logic OSC_EN, // main oscillator enable
	output logic SLEEPING, // low-power state
	input wire logic [7:0] REG_ADDR, // register address
	input wire logic [7:0] REG_WDATA, // register write data
	input wire logic REG_WR, // write strobe
	input wire logic REG_RD, // read strobe
	output logic [7:0] REG_RDATA // read data, one cycle later
);
	localparam int PTR_W = $clog2(STACK_DEPTH);

	iexr_pkg::iexr_state_t state_r;
	iexr_pkg::iexr_state_t state_nxt;
	iexr_pkg::iexr_dec_t dec;
	iexr_pkg::iexr_op_t exec_op;
	iexr_pkg::iexr_alu_t alu;
	logic instr_ready_r;
	logic [12:0] pc_r;
	logic [7:0] w_r;
	logic [7:0] status_r;
	logic [PTR_W-1:0] sp_r;
	logic [12:0] stack_q [STACK_DEPTH];
	logic [7:0] file_q [FILE_WORDS];
	logic [12:0] stack_head;
	logic [7:0] file_val;
	logic [PRESCALE_W-1:0] pre_r;
	logic [7:0] wdog_r;
	logic wdog_ovf;
	logic wake_s1_r;
	logic wake_s2_r;
	logic osc_en_r;
	logic sleeping_r;
	logic [7:0] rdata_r;
	logic [7:0] rd_mux;
	logic take;
	logic ret_op;
	logic file_op;
	logic pop;
	logic sw_file_wr;

	assign INSTR_READY = instr_ready_r;
	assign PC = pc_r;
	assign OSC_EN = osc_en_r;
	assign SLEEPING = sleeping_r;
	assign REG_RDATA = rdata_r;

	// decode by mask and pattern; anything else executes as a no-op
	always_comb begin
		dec.faddr = INSTR_WORD[6:0];
		dec.dest = INSTR_WORD[7];
		dec.lit = INSTR_WORD[7:0];
		dec.op = iexr_pkg::OP_NOP;
		if (INSTR_WORD == `IEXR_OPC_RETURN) begin
			dec.op = iexr_pkg::OP_RETURN;
		end else if (INSTR_WORD == `IEXR_OPC_SLEEP) begin
			dec.op = iexr_pkg::OP_SLEEP;
		end else if ((INSTR_WORD & `IEXR_MASK_RET_LIT) == `IEXR_OPC_RET_LIT) begin
			dec.op = iexr_pkg::OP_RET_LIT;
		end else if ((INSTR_WORD & `IEXR_MASK_LIT_SUB) == `IEXR_OPC_LIT_SUB) begin
			dec.op = iexr_pkg::OP_LIT_SUB;
		end else if ((INSTR_WORD & `IEXR_MASK_OP6) == `IEXR_OPC_XOR_LIT) begin
			dec.op = iexr_pkg::OP_XOR_LIT;
		end else if ((INSTR_WORD & `IEXR_MASK_OP6) == `IEXR_OPC_FILE_SUB) begin
			dec.op = iexr_pkg::OP_FILE_SUB;
		end else if ((INSTR_WORD & `IEXR_MASK_OP6) == `IEXR_OPC_XOR_FILE) begin
			dec.op = iexr_pkg::OP_XOR_FILE;
		end else if ((INSTR_WORD & `IEXR_MASK_OP6) == `IEXR_OPC_ROT_RIGHT) begin
			dec.op = iexr_pkg::OP_ROT_RIGHT;
		end else if ((INSTR_WORD & `IEXR_MASK_OP6) == `IEXR_OPC_NIB_SWAP) begin
			dec.op = iexr_pkg::OP_NIB_SWAP;
		end
	end

	assign take = INSTR_VALID && instr_ready_r;
	assign exec_op = take ? dec.op : iexr_pkg::OP_NOP;
	assign ret_op = (exec_op == iexr_pkg::OP_RET_LIT) || (exec_op == iexr_pkg::OP_RETURN);
	assign file_op = (exec_op == iexr_pkg::OP_ROT_RIGHT)
		|| (exec_op == iexr_pkg::OP_FILE_SUB)
		|| (exec_op == iexr_pkg::OP_XOR_FILE) || (exec_op == iexr_pkg::OP_NIB_SWAP);
	assign pop = ret_op;
	assign stack_head = stack_q[PTR_W'(sp_r - 1'b1)];
	assign file_val = file_q[dec.faddr];
	assign sw_file_wr = REG_WR && (REG_ADDR <= `IEXR_ADDR_FILE_TOP);

	iexr_alu u_alu (
		.op(exec_op),
		.acc(w_r),
		.file_val(file_val),
		.lit(dec.lit),
		.carry_in(status_r[`IEXR_ST_C]),
		.alu(alu)
	);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			iexr_pkg::ST_EXEC: begin
				if (ret_op) begin
					state_nxt = iexr_pkg::ST_FLUSH; // RULE_04
				end else if (exec_op == iexr_pkg::OP_SLEEP) begin
					state_nxt = iexr_pkg::ST_DOZE; // RULE_06
				end
			end
			iexr_pkg::ST_FLUSH: begin
				state_nxt = iexr_pkg::ST_EXEC;
			end
			iexr_pkg::ST_DOZE: begin
				if (wake_s2_r || wdog_ovf) begin
					state_nxt = iexr_pkg::ST_EXEC;
				end
			end
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_r <= iexr_pkg::ST_EXEC;
			instr_ready_r <= 1'b0;
			osc_en_r <= 1'b1;
			sleeping_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			instr_ready_r <= (state_nxt == iexr_pkg::ST_EXEC); // RULE_01
			osc_en_r <= (state_nxt != iexr_pkg::ST_DOZE); // RULE_06
			sleeping_r <= (state_nxt == iexr_pkg::ST_DOZE);
		end
	end

	// wake pin is asynchronous: two flops before anything reads it
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wake_s1_r <= 1'b0;
			wake_s2_r <= 1'b0;
		end else begin
			wake_s1_r <= WAKE;
			wake_s2_r <= wake_s1_r;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pc_r <= `IEXR_PC_RST;
		end else if (take) begin
			if (ret_op) begin
				pc_r <= stack_head; // RULE_01 RULE_04
			end else begin
				pc_r <= pc_r + `IEXR_PC_STEP;
			end
		end
	end

	// a push that collides with a return is dropped; the pop wins
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sp_r <= '0;
		end else if (pop) begin
			sp_r <= PTR_W'(sp_r - 1'b1); // RULE_04
		end else if (PUSH_REQ) begin
			sp_r <= PTR_W'(sp_r + 1'b1);
		end
	end

	// stack wraps like a ring: a ninth push overwrites the oldest entry
	for (genvar gi = 0; gi < STACK_DEPTH; gi++) begin : g_stack
		always_ff @(posedge SYS_CLK or negedge RESET_N) begin
			if (!RESET_N) begin
				stack_q[gi] <= `IEXR_PC_RST;
			end else if (PUSH_REQ && !pop && (sp_r == PTR_W'(gi))) begin
				stack_q[gi] <= PUSH_ADDR;
			end
		end
	end

	// the executing instruction outranks a software write to the same byte
	for (genvar gf = 0; gf < FILE_WORDS; gf++) begin : g_file
		always_ff @(posedge SYS_CLK or negedge RESET_N) begin
			if (!RESET_N) begin
				file_q[gf] <= `IEXR_FILE_RST;
			end else if (file_op && dec.dest && (dec.faddr == 7'(gf))) begin
				file_q[gf] <= alu.res; // RULE_03
			end else if (sw_file_wr && (REG_ADDR[6:0] == 7'(gf))) begin
				file_q[gf] <= REG_WDATA;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			w_r <= `IEXR_ACC_RST;
		end else if (exec_op == iexr_pkg::OP_RET_LIT) begin
			w_r <= dec.lit; // RULE_01
		end else if (exec_op == iexr_pkg::OP_LIT_SUB || exec_op == iexr_pkg::OP_XOR_LIT) begin
			w_r <= alu.res; // RULE_07 RULE_08
		end else if (file_op && !dec.dest) begin
			w_r <= alu.res; // RULE_03
		end else if (REG_WR && REG_ADDR == `IEXR_ADDR_ACC) begin
			w_r <= REG_WDATA;
		end
	end

	// hardware flag updates follow the software write so they win
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			status_r <= `IEXR_STAT_RST;
		end else begin
			if (REG_WR && REG_ADDR == `IEXR_ADDR_STAT) begin
				status_r <= REG_WDATA & `IEXR_STAT_MASK;
			end
			if (alu.wr_c) begin
				status_r[`IEXR_ST_C] <= alu.c; // RULE_02 RULE_12
			end
			if (alu.wr_hb) begin
				status_r[`IEXR_ST_HB] <= alu.hb; // RULE_07 RULE_09
			end
			if (alu.wr_z) begin
				status_r[`IEXR_ST_Z] <= alu.z; // RULE_08 RULE_10
			end
			if (wdog_ovf) begin
				status_r[`IEXR_ST_WDEXP] <= 1'b0;
			end
			if (exec_op == iexr_pkg::OP_SLEEP) begin
				status_r[`IEXR_ST_WDEXP] <= 1'b1; // RULE_05
				status_r[`IEXR_ST_PWRDN] <= 1'b0; // RULE_05
			end
		end
	end

	// watchdog keeps its own pace while the main oscillator is stopped
	assign wdog_ovf = (&pre_r) && (wdog_r == `IEXR_WDOG_TOP);

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pre_r <= '0;
			wdog_r <= `IEXR_WDOG_CLR;
		end else if (exec_op == iexr_pkg::OP_SLEEP) begin
			pre_r <= '0; // RULE_05
			wdog_r <= `IEXR_WDOG_CLR; // RULE_05
		end else if (REG_WR && REG_ADDR == `IEXR_ADDR_WDOG) begin
			pre_r <= '0;
			wdog_r <= `IEXR_WDOG_CLR;
		end else begin
			pre_r <= PRESCALE_W'(pre_r + 1'b1);
			if (&pre_r) begin
				wdog_r <= 8'(wdog_r + 1'b1);
			end
		end
	end

	always_comb begin
		rd_mux = `IEXR_RDATA_IDLE;
		if (REG_ADDR <= `IEXR_ADDR_FILE_TOP) begin
			rd_mux = file_q[REG_ADDR[6:0]];
		end else if (REG_ADDR == `IEXR_ADDR_ACC) begin
			rd_mux = w_r;
		end else if (REG_ADDR == `IEXR_ADDR_STAT) begin
			rd_mux = status_r;
		end else if (REG_ADDR == `IEXR_ADDR_WDOG) begin
			rd_mux = wdog_r;
		end
	end

	// read data stand in each cycle after a strobed one, zero otherwise
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rdata_r <= `IEXR_RDATA_IDLE;
		end else if (REG_RD) begin
			rdata_r <= rd_mux;
		end else begin
			rdata_r <= `IEXR_RDATA_IDLE;
		end
	end

	AST_RET_LIT_LOAD: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // RULE_01
		(exec_op == iexr_pkg::OP_RET_LIT && !REG_WR) |=> (w_r == $past(dec.lit))
		&& (pc_r == $past(stack_head)) && (status_r[2:0] == $past(status_r[2:0])))
		else $error("return with literal did not load accumulator and pc");

	AST_RET_TWO_CYCLE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // RULE_04
		ret_op |=> !instr_ready_r ##1 instr_ready_r)
		else $error("return did not take two cycles");

	AST_RET_POP: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // RULE_04
		(exec_op == iexr_pkg::OP_RETURN) |=> (sp_r == PTR_W'($past(sp_r) - 1'b1))
		&& (pc_r == $past(stack_head)))
		else $error("return did not pop the stack");

	AST_ROT_CARRY: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // RULE_02
		(exec_op == iexr_pkg::OP_ROT_RIGHT && !dec.dest && !REG_WR) |=>
		(status_r[`IEXR_ST_C] == $past(file_val[0]))
		&& (w_r == {$past(status_r[`IEXR_ST_C]), $past(file_val[7:1])})
		&& (status_r[`IEXR_ST_Z] == $past(status_r[`IEXR_ST_Z])))
		else $error("rotate right through carry wrong");

	AST_DEST_FILE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // RULE_03
		(file_op && dec.dest) |=> (file_q[$past(dec.faddr)] == $past(alu.res))
		&& (w_r == $past(w_r)))
		else $error("destination one did not write the file register");

	AST_SLEEP_FLAGS: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // RULE_05
		(exec_op == iexr_pkg::OP_SLEEP) |=> (wdog_r == `IEXR_WDOG_CLR) && (pre_r == '0)
		&& status_r[`IEXR_ST_WDEXP] && !status_r[`IEXR_ST_PWRDN])
		else $error("power-down flags or watchdog wrong");

	AST_SLEEP_OSC: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // RULE_06
		(exec_op == iexr_pkg::OP_SLEEP) |=> !osc_en_r && sleeping_r && !instr_ready_r)
		else $error("oscillator still running after power-down");

	AST_LIT_SUB: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // RULE_07
		(exec_op == iexr_pkg::OP_LIT_SUB && !REG_WR) |=>
		(w_r == 8'($past(dec.lit) - $past(w_r)))
		&& (status_r[`IEXR_ST_C] == ($past(dec.lit) >= $past(w_r)))
		&& (status_r[`IEXR_ST_Z] == (w_r == 8'h00)))
		else $error("literal minus accumulator wrong");

	AST_FILE_SUB_FLAGS: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // RULE_09
		(exec_op == iexr_pkg::OP_FILE_SUB && !REG_WR) |=>
		(status_r[`IEXR_ST_C] == ($past(file_val) >= $past(w_r)))
		&& (status_r[`IEXR_ST_HB] == ($past(file_val[3:0]) >= $past(w_r[3:0]))))
		else $error("file minus accumulator flags wrong");

	AST_XOR_FLAGS: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // RULE_10
		((exec_op == iexr_pkg::OP_XOR_FILE || exec_op == iexr_pkg::OP_XOR_LIT)
		&& !REG_WR) |=>
		(status_r[1:0] == $past(status_r[1:0])))
		else $error("xor touched carry or half flag");

	AST_SWAP: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // RULE_11
		(exec_op == iexr_pkg::OP_NIB_SWAP && !dec.dest && !REG_WR) |=>
		(w_r == {$past(file_val[3:0]), $past(file_val[7:4])})
		&& (status_r[2:0] == $past(status_r[2:0])))
		else $error("nibble exchange wrong");
endmodule : iexr_core

// ==== hdl/iexr_pkg.sv ====
// types shared by the execution core and its arithmetic unit
package iexr_pkg;
	typedef enum logic [3:0] {
		OP_NOP,
		OP_RET_LIT,
		OP_RETURN,
		OP_ROT_RIGHT,
		OP_SLEEP,
		OP_LIT_SUB,
		OP_XOR_LIT,
		OP_FILE_SUB,
		OP_XOR_FILE,
		OP_NIB_SWAP
	} iexr_op_t;
	typedef enum {ST_EXEC, ST_FLUSH, ST_DOZE} iexr_state_t;
	typedef struct packed {
		iexr_op_t op;
		logic dest;
		logic [6:0] faddr;
		logic [7:0] lit;
	} iexr_dec_t;
	typedef struct packed {
		logic [7:0] res;
		logic c;
		logic hb;
		logic z;
		logic wr_c;
		logic wr_hb;
		logic wr_z;
	} iexr_alu_t;
endpackage : iexr_pkg

// ==== hdl/iexr_regs.svh ====
// offsets, field positions, reset values, opcode patterns and counts
`ifndef IEXR_REGS_SVH
`define IEXR_REGS_SVH
`define IEXR_ADDR_FILE_TOP 8'h7F
`define IEXR_ADDR_ACC 8'h80
`define IEXR_ADDR_STAT 8'h81
`define IEXR_ADDR_WDOG 8'h82
`define IEXR_ST_C 0
`define IEXR_ST_HB 1
`define IEXR_ST_Z 2
`define IEXR_ST_PWRDN 3
`define IEXR_ST_WDEXP 4
`define IEXR_STAT_MASK 8'h1F
`define IEXR_STAT_RST 8'h18
`define IEXR_ACC_RST 8'h00
`define IEXR_FILE_RST 8'h00
`define IEXR_RDATA_IDLE 8'h00
`define IEXR_PC_RST 13'h0000
`define IEXR_PC_STEP 13'h0001
`define IEXR_WDOG_CLR 8'h00
`define IEXR_WDOG_TOP 8'hFF
`define IEXR_OPC_RETURN 14'h0008
`define IEXR_OPC_SLEEP 14'h0063
`define IEXR_MASK_RET_LIT 14'h3C00
`define IEXR_OPC_RET_LIT 14'h3400
`define IEXR_MASK_LIT_SUB 14'h3E00
`define IEXR_OPC_LIT_SUB 14'h3C00
`define IEXR_MASK_OP6 14'h3F00
`define IEXR_OPC_XOR_LIT 14'h3A00
`define IEXR_OPC_FILE_SUB 14'h0200
`define IEXR_OPC_XOR_FILE 14'h0600
`define IEXR_OPC_ROT_RIGHT 14'h0C00
`define IEXR_OPC_NIB_SWAP 14'h0E00
`endif

// ==== testbench/iexr_core_bench.sv ====
// self-checking bench for the instruction execution core
`timescale 1ns/10ps
`include "iexr_regs.svh"
module iexr_core_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic valid;
	logic [13:0] word;
	logic ready;
	logic [12:0] pc;
	logic push = 1'b0;
	logic [12:0] push_addr = 13'h0000;
	logic wake = 1'b0;
	logic osc_en;
	logic sleeping;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic load = 1'b0;
	logic [13:0] load_word = 14'h0000;
	logic stall = 1'b0;
	logic [7:0] v;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	int n;

	// short prescaler keeps the watchdog wake within about a thousand cycles
	iexr_core #(.PRESCALE_W(2)) uut (.SYS_CLK(clk), .RESET_N(rst_n), .INSTR_VALID(valid),
		.INSTR_WORD(word), .INSTR_READY(ready), .PC(pc), .PUSH_REQ(push),
		.PUSH_ADDR(push_addr), .WAKE(wake), .OSC_EN(osc_en), .SLEEPING(sleeping),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));
	iexr_prog_model prog (.clk(clk), .rst_n(rst_n), .ready(ready), .stall(stall),
		.load(load), .load_word(load_word), .valid(valid), .word(word));

	initial begin
		forever #12.5 clk = ~clk;
	end

	task results;
		if (errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results

	task check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// read data stand only in the cycle after the strobe
	task rd_reg(input logic [7:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg

	task push_ret(input logic [12:0] a);
		@(posedge clk);
		push <= 1'b1;
		push_addr <= a;
		@(posedge clk);
		push <= 1'b0;
	endtask : push_ret

	// returns just after the edge that took the word
	task exec(input logic [13:0] w, input bit slow);
		int k;
		@(posedge clk);
		load <= 1'b1;
		load_word <= w;
		stall <= slow;
		@(posedge clk);
		load <= 1'b0;
		if (slow) begin
			repeat (3) @(posedge clk);
			stall <= 1'b0;
		end
		for (k = 0; k < 10; k++) begin
			@(posedge clk);
			#1;
			if (!valid) break;
		end
		if (k == 10) begin
			errors++;
			$display("[FAIL] %0t word never taken", $time);
		end
	endtask : exec

	// preload file, accumulator and flags, run one word, compare all three
	task op(input logic [13:0] w14, input logic [7:0] fv, input logic [7:0] w,
		input logic [7:0] st, input logic [7:0] ew, input logic [7:0] ef,
		input logic [7:0] est, input bit slow);
		wr_reg({1'b0, w14[6:0]}, fv);
		wr_reg(`IEXR_ADDR_ACC, w);
		wr_reg(`IEXR_ADDR_STAT, st);
		exec(w14, slow);
		rd_reg(`IEXR_ADDR_ACC);
		check(v, ew);
		rd_reg({1'b0, w14[6:0]});
		check(v, ef);
		rd_reg(`IEXR_ADDR_STAT);
		check(v, est);
	endtask : op

	task t_reset;
		rd_reg(`IEXR_ADDR_STAT);
		check(v, 8'h18);
		rd_reg(`IEXR_ADDR_ACC);
		check(v, 8'h00);
	endtask : t_reset

	task t_alu;
		op(14'h3C03, 8'h03, 8'h05, 8'h1F, 8'hFE, 8'h03, 8'h18, 1'b0);
		op(14'h3D03, 8'h03, 8'h03, 8'h18, 8'h00, 8'h03, 8'h1F, 1'b1);
		op(14'h02FF, 8'h10, 8'h01, 8'h18, 8'h01, 8'h0F, 8'h19, 1'b0);
		op(14'h027F, 8'h42, 8'h42, 8'h18, 8'h00, 8'h42, 8'h1F, 1'b1);
		op(14'h3A5A, 8'h5A, 8'h5A, 8'h1B, 8'h00, 8'h5A, 8'h1F, 1'b0);
		op(14'h0680, 8'hF0, 8'h0F, 8'h1C, 8'h0F, 8'hFF, 8'h18, 1'b0);
		op(14'h0C41, 8'h40, 8'h77, 8'h1F, 8'hA0, 8'h40, 8'h1E, 1'b0);
		op(14'h0C81, 8'h03, 8'h77, 8'h18, 8'h77, 8'h01, 8'h19, 1'b0);
		op(14'h0E3C, 8'hA5, 8'h11, 8'h1D, 8'h5A, 8'hA5, 8'h1D, 1'b0);
		op(14'h0EBC, 8'h0F, 8'h11, 8'h1A, 8'h11, 8'hF0, 8'h1A, 1'b0);
	endtask : t_alu

	task t_return;
		push_ret(13'h0123);
		push_ret(13'h1ABC);
		wr_reg(`IEXR_ADDR_STAT, 8'h1D);
		exec(14'h37AB, 1'b0);
		check(pc, 13'h1ABC);
		check(ready, 1'b0);
		@(posedge clk);
		#1 check(ready, 1'b1);
		exec(`IEXR_OPC_RETURN, 1'b0);
		check(pc, 13'h0123);
		check(ready, 1'b0);
		rd_reg(`IEXR_ADDR_ACC);
		check(v, 8'hAB);
		rd_reg(`IEXR_ADDR_STAT);
		check(v, 8'h1D);
	endtask : t_return

	task t_sleep;
		exec(`IEXR_OPC_SLEEP, 1'b0);
		check(sleeping, 1'b1);
		check(osc_en, 1'b0);
		check(ready, 1'b0);
		rd_reg(`IEXR_ADDR_WDOG);
		check(v, 8'h00);
		rd_reg(`IEXR_ADDR_STAT);
		check(v[4:3], 2'b10);
		@(posedge clk);
		wake <= 1'b1;
		for (n = 0; n < 6; n++) begin
			@(posedge clk);
			#1;
			if (!sleeping) break;
		end
		@(posedge clk);
		wake <= 1'b0;
		check(osc_en, 1'b1);
		check(n < 6, 1'b1);
		// let the watchdog run so a missed clear would shorten the next doze
		repeat (500) @(posedge clk);
		exec(`IEXR_OPC_SLEEP, 1'b0);
		for (n = 0; n < 1100; n++) begin
			@(posedge clk);
			#1;
			if (!sleeping) break;
		end
		check(n > 1000 && n < 1100, 1'b1);
		rd_reg(`IEXR_ADDR_STAT);
		check(v[4:3], 2'b00);
	endtask : t_sleep

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			errors++;
			$display("[FAIL] %0t run did not finish", $time);
			results;
		end
	end

	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_alu;
		t_return;
		t_sleep;
		results;
	end
endmodule : iexr_core_bench

// ==== testbench/iexr_prog_model.sv ====
// program memory model: queues instruction words and offers them to the core
`timescale 1ns/10ps
module iexr_prog_model (
	input wire logic clk, // core clock
	input wire logic rst_n, // asynchronous reset
	input wire logic ready, // core takes the word
	input wire logic stall, // slow memory: withhold the word
	input wire logic load, // append a word
	input wire logic [13:0] load_word, // word to append
	output logic valid, // word offered
	output logic [13:0] word // offered word
);
	logic [13:0] mem_r [0:15];
	logic [3:0] wp_r;
	logic [3:0] rp_r;
	logic [13:0] last_r;
	assign valid = !stall && (wp_r != rp_r);
	// idle bus shows the inverse so a stale word never passes for a fresh one
	assign word = valid ? mem_r[rp_r] : ~last_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= 4'h0;
			rp_r <= 4'h0;
			last_r <= 14'h0000;
		end else begin
			if (load) begin
				mem_r[wp_r] <= load_word;
				wp_r <= wp_r + 4'h1;
			end
			if (valid && ready) begin
				rp_r <= rp_r + 4'h1;
				last_r <= word;
			end
		end
	end
endmodule : iexr_prog_model
